// ### rtl/teds_edge_select.sv
// Purpose: Edge-select control register and edge detector for the timer input pin.
// Assumes: APB master, pin asynchronous to clk_sys.
// Notes: Bit writes use pstrb-free masked write register at offset 0x008.
// Summary of operation
// - One 8-bit register, event and trigger fields.
// - Low-nibble and single-bit access (bits 7:4 stay zero), others kept.
// - Reset clears register to zero.
// - Trigger codes: 00 off, 10 fall, 11 both.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module teds_edge_select (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_pin,
  output logic event_count_strobe,
  output logic ext_trigger_strobe
);
  // ==========================================================
  // Edge decode
  // ==========================================================
  // Shared edge decode.
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
    edge_hit = (sel[0] & rise) | (sel[1] & fall);
  endfunction

  // Selects one edge field of the register.
  function automatic logic [1:0] field_of(input logic [7:0] ctrl, input int pos);
    field_of = ctrl[pos +: teds_pkg::FIELD_W];
  endfunction

  // ==========================================================
  // Storage and pin history
  // ==========================================================
  logic [7:0] ext_input_edge_control;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic access_phase;
  logic setup_phase;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_bit;
  logic unmapped;
  logic ctrl_write;
  logic [2:0] bit_idx;
  logic bit_val;
  logic [7:0] bit_mask;
  logic [7:0] bit_written;
  logic [7:0] next_ctrl;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;

  assign access_phase = psel & penable;
  assign setup_phase = psel & ~penable;
  assign hit_ctrl = paddr == teds_pkg::ADDR_EDGE_CTRL;
  assign hit_stat = paddr == teds_pkg::ADDR_PIN_STATUS;
  assign hit_bit = paddr == teds_pkg::ADDR_BIT_ACCESS;
  assign unmapped = ~(hit_ctrl | hit_stat | hit_bit);
  assign ctrl_write = access_phase & pwrite & pready & (hit_ctrl | hit_bit);
  assign bit_idx = pwdata[teds_pkg::BIT_IDX_POS +: 3];
  assign bit_val = pwdata[teds_pkg::BIT_VAL_POS];
  assign bit_mask = 8'h01 << bit_idx;
  assign bit_written = bit_val ? (ext_input_edge_control | bit_mask) : (ext_input_edge_control & ~bit_mask);
  assign next_ctrl = hit_bit ? {4'h0, bit_written[3:0]} : {4'h0, pwdata[3:0]};
  assign next_pready = setup_phase;
  assign next_pslverr = setup_phase & unmapped;
  assign next_prdata = hit_ctrl ? {24'h000000, ext_input_edge_control}
                     : hit_stat ? {31'h0, pin_sync} : 32'h00000000;

  // ==========================================================
  // Edge detection
  // ==========================================================
  logic [1:0] event_count_edge;
  logic [1:0] ext_trigger_edge;
  logic rise;
  logic fall;
  logic next_event_strobe;
  logic next_trigger_strobe;

  assign event_count_edge = field_of(ext_input_edge_control, teds_pkg::EVT_LO_POS);
  assign ext_trigger_edge = field_of(ext_input_edge_control, teds_pkg::TRIG_LO_POS);
  assign rise = pin_sync & ~pin_prev;
  assign fall = ~pin_sync & pin_prev;
  assign next_event_strobe = edge_hit(event_count_edge, rise, fall);
  assign next_trigger_strobe = edge_hit(ext_trigger_edge, rise, fall);

  // ==========================================================
  // Register
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ext_input_edge_control <= teds_pkg::EDGE_CTRL_RESET;
    end
    else if (ctrl_write)
    begin
      ext_input_edge_control <= next_ctrl;
    end
  end

  // ==========================================================
  // Bus response
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pready <= 1'h0;
    end
    else
    begin
      pready <= next_pready;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pslverr <= 1'h0;
    end
    else
    begin
      pslverr <= next_pslverr;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
    end
    else
    begin
      prdata <= next_prdata;
    end
  end

  // ==========================================================
  // Pin synchroniser
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_meta <= 1'h0;
    end
    else
    begin
      pin_meta <= timer_input_pin;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_sync <= 1'h0;
    end
    else
    begin
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pin_prev <= 1'h0;
    end
    else
    begin
      pin_prev <= pin_sync;
    end
  end

  // ==========================================================
  // Strobes
  // ==========================================================
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      event_count_strobe <= 1'h0;
    end
    else
    begin
      event_count_strobe <= next_event_strobe;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ext_trigger_strobe <= 1'h0;
    end
    else
    begin
      ext_trigger_strobe <= next_trigger_strobe;
    end
  end
endmodule

// ### rtl/teds_pkg.sv
// Purpose: Constants for the timer input edge-select block.
// Assumes: APB slave with 32-bit data, three register words.
// Notes: Field positions follow the control register layout.
package teds_pkg;
  // ==========================================================
  // Register map
  // ==========================================================
  localparam logic [11:0] ADDR_EDGE_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PIN_STATUS = 12'h004;
  localparam logic [11:0] ADDR_BIT_ACCESS = 12'h008;
  localparam logic [7:0] EDGE_CTRL_RESET = 8'h00;
  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int TRIG_LO_POS = 0;
  localparam int EVT_LO_POS = 2;
  localparam int FIELD_W = 2;
  localparam int BIT_IDX_POS = 0;
  localparam int BIT_VAL_POS = 8;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// ### testbench/teds_checker.sv
// Purpose: port checks. Assumes: APB. Notes: bound below.
`timescale 1ns/1ps
module teds_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic timer_input_pin,
  input wire logic event_count_strobe,
  input wire logic ext_trigger_strobe);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ready_one: assert property (pready |=> !pready) else $error("ready held");
  a_upper_zero: assert property (pready |-> prdata[31:4] == 28'h0) else $error("upper bits");
  a_reset_quiet: assert property ($fell(rst) |-> !pready && !ext_trigger_strobe && !event_count_strobe) else $error("reset");
  a_trig_edge: assert property (ext_trigger_strobe |-> $past(timer_input_pin, 3) != $past(timer_input_pin, 4)) else $error("trigger without edge");
  a_event_edge: assert property (event_count_strobe |-> $past(timer_input_pin, 3) != $past(timer_input_pin, 4)) else $error("event without edge");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
endmodule
bind teds_edge_select teds_checker chk_u (.*);

// ### testbench/teds_pulse_src.sv
// Purpose: pin source. Assumes: idles low. Notes: toggle flips pin.
`timescale 1ns/1ps
module teds_pulse_src (
  input wire logic clk_sys,
  input wire logic toggle,
  output logic timer_input_pin = 1'h0);
  always @(posedge clk_sys) if (toggle) timer_input_pin <= ~timer_input_pin;
endmodule

// ### testbench/tb.sv
// Purpose: bench. Assumes: APB. Notes: none.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH %s %0h %0h", n, e, g); end end
module tb;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, toggle = 0, pready, pslverr, er;
  logic timer_input_pin, event_count_strobe, ext_trigger_strobe; int error_cnt = 0, samples_checked = 0, ne, nt, i;
  logic [11:0] paddr = 0; logic [31:0] pwdata = 0, prdata, rd;
  always #5 clk_sys = ~clk_sys;
  teds_edge_select dut_u (.*);
  teds_pulse_src src_u (.*);
  task stop_test(int t);
    $display("checks %0d errors %0d", samples_checked, error_cnt + t);
    if (error_cnt + t == 0 && samples_checked > 0) $display("ALL CHECKS OK"); else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge clk_sys) penable <= 1;
    for (i = 0; i < 20; i++) begin @(posedge clk_sys); if (pready === 1) break; end
    if (i == 20) stop_test(1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 0;
  endtask
  task regs;
    apb(0, 0, 0); `CHK("reset", 0, rd)
    apb(0, 4, 0); `CHK("status", 0, rd)
    apb(1, 0, 'hFF); apb(1, 8, 2); apb(0, 0, 0); `CHK("bits", 'hB, rd)
    apb(1, 8, 'h102); apb(0, 0, 0); `CHK("bitset", 'hF, rd)
    apb(0, 'hFFC, 0); `CHK("slverr", 1, er)
    $display("regs end");
  endtask
  task edges(logic [3:0] v, int xe, int xt);
    apb(1, 0, v); {ne, nt} = 0;
    @(posedge clk_sys) toggle <= 1; @(posedge clk_sys) toggle <= 0;
    repeat (8) @(posedge clk_sys) #1 {ne, nt} = {ne + event_count_strobe, nt + ext_trigger_strobe};
    `CHK("counts", {xe, xt}, {ne, nt})
    $display("edge %0h %0d %0d end", v, xe, xt);
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys); rst <= 0; regs;
    for (int c = 0; c < 8; c++) edges({2'(c / 2), 2'(c / 2)}, (c / 2 >> c % 2) & 1, (c / 2 >> c % 2) & 1);
    edges('h6, 1, 0); edges('h6, 0, 1); stop_test(0);
  end
endmodule
